// ### dv/pin_port_model.sv
`timescale 1ns/1ps
`default_nettype none

module pin_port_model (
    input wire logic ref_clk,
    input wire pin_irq_pkg::port_pins_t level_cmd,
    output var pin_irq_pkg::port_pins_t pins
);
    import pin_irq_pkg::*;

    // Outside source moves its pins just after a clock edge
    always @(posedge ref_clk) begin
        pins <= level_cmd;
    end
endmodule

`default_nettype wire

// ### dv/test_pin_interrupt_flags_priority.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end

module test_pin_interrupt_flags_priority;
    import pin_irq_pkg::*;

    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    bus_req_t req = '0;
    port_pins_t pin_cmd = '0;
    port_pins_t pins;
    logic [7:0] reg_rdata;
    logic pin_irq_req;
    prio_levels_t ext_prio_level;
    logic irq;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] exp_v;

    // Clock at 25 MHz
    always #20 ref_clk = ~ref_clk;

    pin_port_model pins_u (.ref_clk(ref_clk), .level_cmd(pin_cmd), .pins(pins));

    pin_irq_flags dut_u (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .port_pins(pins),
        .reg_req(req),
        .reg_rdata(reg_rdata),
        .pin_irq_req(pin_irq_req),
        .ext_prio_level(ext_prio_level),
        .irq(irq)
    );

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask

    // Read request; expected byte noted for the monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        exp_q.push_back(e);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
    endtask

    // Write, then read back in the very next cycle
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        exp_q.push_back(e);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic set_pins(input port_pins_t v);
        @(posedge ref_clk);
        pin_cmd <= v;
    endtask

    // Read data checked in the one cycle it stands
    always @(posedge ref_clk) begin
        if (rd_seen) begin
            exp_v = exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX;
            `CHK(reg_rdata, exp_v)
        end
        rd_seen <= req.rd;
    end

    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            test_done();
        end
    end

    initial begin
        port_pins_t pv;
        logic [7:0] lo;
        logic [7:0] hi;
        void'($urandom(32'hE46D1A17));
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        // Reset values and two unmapped places
        rd(OFS_PIN_IRQ_CONTROL, 8'h00);
        rd(OFS_FALLING_LOW_EN, 8'h00);
        rd(OFS_RISING_HIGH_EN, 8'h00);
        rd(OFS_EXT_PRIO_LOW, 8'h00);
        rd(OFS_EXT_PRIO_HIGH, 8'h00);
        rd(OFS_IRQ_MASK, 8'h00);
        rd(8'h00, 8'h00);
        rd(8'hED, 8'h00);
        settle(6);
        rd(OFS_PIN_EVENT_FLAGS, 8'hFF);
        // Level flags follow the inverse pins of each selected port
        for (int p = 0; p < 4; p++) begin
            pv = port_pins_t'($urandom);
            wr(OFS_PIN_IRQ_CONTROL, 8'(p));
            set_pins(pv);
            settle(6);
            rd(OFS_PIN_EVENT_FLAGS, ~pv[p]);
        end
        // Level flags ignore writes
        wr_rd(OFS_PIN_EVENT_FLAGS, pv[3], ~pv[3]);
        // Priority level per source is {high, low}
        lo = 8'($urandom);
        hi = 8'($urandom);
        wr(OFS_EXT_PRIO_LOW, lo);
        wr(OFS_EXT_PRIO_HIGH, hi);
        settle(2);
        for (int i = 0; i < 8; i++) begin
            `CHK(ext_prio_level[i], {hi[i], lo[i]})
        end
        rd(OFS_EXT_PRIO_LOW, lo);
        // Edge mode, port 0, rising on 0..3 and falling on 4..7
        set_pins('0);
        settle(6);
        wr(OFS_PIN_IRQ_CONTROL, 8'hFC);
        wr(OFS_FALLING_LOW_EN, 8'hF0);
        wr(OFS_RISING_HIGH_EN, 8'h0F);
        wr(OFS_PIN_EVENT_FLAGS, 8'h00);
        rd(OFS_PIN_EVENT_FLAGS, 8'h00);
        set_pins(32'h0000_00FF);
        settle(6);
        rd(OFS_PIN_EVENT_FLAGS, 8'h0F);
        set_pins('0);
        settle(6);
        rd(OFS_PIN_EVENT_FLAGS, 8'hFF);
        // Software clears the flags; they stay clear with quiet pins
        wr(OFS_PIN_EVENT_FLAGS, 8'h00);
        wr(OFS_IRQ_MASK, 8'h00);
        wr(OFS_IRQ_STATUS, 8'hFF);
        settle(4);
        rd(OFS_PIN_EVENT_FLAGS, 8'h00);
        `CHK(pin_irq_req, 1'b0)
        // Masked event, then unmask and clear by writing one
        set_pins(32'h0000_00FF);
        settle(6);
        `CHK(pin_irq_req, 1'b1)
        `CHK(irq, 1'b0)
        rd(OFS_IRQ_STATUS, 8'h0F);
        wr(OFS_IRQ_MASK, 8'h01);
        settle(2);
        `CHK(irq, 1'b1)
        wr(OFS_IRQ_STATUS, 8'h01);
        settle(2);
        `CHK(irq, 1'b0)
        rd(OFS_IRQ_STATUS, 8'h0E);
        rd(OFS_PIN_EVENT_FLAGS, 8'h0F);
        // Falling edge on 4..7 meets a same-cycle clear of every flag
        set_pins('0);
        settle(3);
        wr(OFS_PIN_EVENT_FLAGS, 8'h00);
        rd(OFS_PIN_EVENT_FLAGS, 8'hF0);
        rd(OFS_IRQ_STATUS, 8'hFE);
        settle(3);
        test_done();
    end
endmodule

`default_nettype wire

// ### hw/pin_irq_flags.sv
// Behaviour
// - Edge mode sets a channel flag when an enabled edge is seen.
// - Level mode flag always equals the inverse of the channel input level.
// - Level-mode flags ignore writes; edge-mode flags are readable and writable.
// - Flag register holds channel n at bit n, eight channels, reset zero.
// - Priority-low bits: 7 timer two down to 0 two-wire bus.
// - Each extended source level combines its high and low priority bits.
// - Type select per channel or pair: 0 level, 1 edge.
// - Negative enable arms low level or falling edge per channel; the code uses it for falling edges only, and level flags ignore it.
// - Positive enable arms high level or rising edge per channel; the code uses it for rising edges only, and level flags ignore it.
// - Two-bit port select picks port 0 to 3 for the channels.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pin_irq_flags (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire pin_irq_pkg::port_pins_t port_pins,
    input wire pin_irq_pkg::bus_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic pin_irq_req,
    output pin_irq_pkg::prio_levels_t ext_prio_level,
    output logic irq
);
    import pin_irq_pkg::*;

    port_pins_t port_sync;
    logic [7:0] pin_irq_control_reg;
    logic [7:0] falling_low_enable_reg;
    logic [7:0] rising_high_enable_reg;
    logic [7:0] pin_event_flags_reg;
    logic [7:0] pin_event_flags_next;
    logic [7:0] ext_irq_priority_low_reg;
    logic [7:0] ext_irq_priority_high_reg;
    logic [7:0] irq_status_reg;
    logic [7:0] irq_mask_reg;
    logic [7:0] chan_cur_reg;
    logic [7:0] chan_prev_reg;
    logic [7:0] chan_now;
    logic [7:0] edge_mask;
    logic [7:0] rise_seen;
    logic [7:0] fall_seen;
    logic [7:0] edge_set;
    logic [7:0] flag_rise;
    logic [7:0] rdata_reg;
    logic irq_reg;
    logic pin_irq_reg;
    logic started_reg;
    logic [1:0] port_group_select;
    logic wr_control;
    logic wr_flags;
    logic wr_status;

    // Channel trigger type from the control byte
    function automatic logic [7:0] trigger_type_select(input logic [7:0] ctl);
        trigger_type_select = {ctl[CTL_TYPE_67], ctl[CTL_TYPE_67],
                               ctl[CTL_TYPE_45], ctl[CTL_TYPE_45],
                               ctl[CTL_TYPE_3:CTL_TYPE_0]};
    endfunction

    // Write strobe decode for one offset
    function automatic logic write_hit(input bus_req_t req, input logic [7:0] ofs);
        write_hit = req.wr && (req.addr == ofs);
    endfunction

    // Pin synchroniser for all four ports
    pin_sync #(
        .WIDTH(32)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in(port_pins),
        .sync_out(port_sync)
    );

    assign port_group_select = pin_irq_control_reg[CTL_PSEL_MSB:CTL_PSEL_LSB];
    assign chan_now = port_sync[port_group_select];

    assign edge_mask = trigger_type_select(pin_irq_control_reg);

    // current and previous sample of the chosen channels
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            chan_cur_reg <= RST_BYTE;
            chan_prev_reg <= RST_BYTE;
        end else begin
            chan_cur_reg <= chan_now;
            chan_prev_reg <= chan_cur_reg;
        end
    end

    // rising edges armed by the positive enable
    assign rise_seen = chan_cur_reg & ~chan_prev_reg & rising_high_enable_reg;
    // falling edges armed by the negative enable
    assign fall_seen = ~chan_cur_reg & chan_prev_reg & falling_low_enable_reg;
    assign edge_set = (rise_seen | fall_seen) & edge_mask;

    assign wr_control = write_hit(reg_req, OFS_PIN_IRQ_CONTROL);
    assign wr_flags = write_hit(reg_req, OFS_PIN_EVENT_FLAGS);
    assign wr_status = write_hit(reg_req, OFS_IRQ_STATUS);

    // Flag next value per channel
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            if (edge_mask[n] == TYPE_EDGE) begin
                // set wins over a software write
                if (edge_set[n]) begin
                    pin_event_flags_next[n] = 1'b1;
                // software clears or writes the edge flag
                end else if (wr_flags) begin
                    pin_event_flags_next[n] = reg_req.wdata[n];
                end else begin
                    pin_event_flags_next[n] = pin_event_flags_reg[n];
                end
            end else begin
                // level flag follows the inverted input
                pin_event_flags_next[n] = ~chan_cur_reg[n];
            end
        end
    end

    // flag register, channel n at bit n
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pin_event_flags_reg <= RST_BYTE;
        end else begin
            pin_event_flags_reg <= pin_event_flags_next;
        end
    end

    // Control and polarity enable registers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pin_irq_control_reg <= {RST_BYTE[7:2], RST_PORT_SEL};
            falling_low_enable_reg <= RST_BYTE;
            rising_high_enable_reg <= RST_BYTE;
        end else begin
            if (wr_control) begin
                pin_irq_control_reg <= reg_req.wdata;
            end
            if (write_hit(reg_req, OFS_FALLING_LOW_EN)) begin
                falling_low_enable_reg <= reg_req.wdata;
            end
            if (write_hit(reg_req, OFS_RISING_HIGH_EN)) begin
                rising_high_enable_reg <= reg_req.wdata;
            end
        end
    end

    // priority low and high bits per extended source
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ext_irq_priority_low_reg <= RST_BYTE;
            ext_irq_priority_high_reg <= RST_BYTE;
        end else begin
            if (write_hit(reg_req, OFS_EXT_PRIO_LOW)) begin
                ext_irq_priority_low_reg <= reg_req.wdata;
            end
            if (write_hit(reg_req, OFS_EXT_PRIO_HIGH)) begin
                ext_irq_priority_high_reg <= reg_req.wdata;
            end
        end
    end

    // level is {high bit, low bit} of each source
    always_comb begin
        for (int s = 0; s < 8; s++) begin
            ext_prio_level[s] = {ext_irq_priority_high_reg[s], ext_irq_priority_low_reg[s]};
        end
    end

    // Flag rising into one, the interrupt status event
    assign flag_rise = pin_event_flags_next & ~pin_event_flags_reg;

    // Sticky status, write one to clear, new event wins
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_status_reg <= RST_BYTE;
        end else if (wr_status) begin
            irq_status_reg <= (irq_status_reg & ~reg_req.wdata) | flag_rise;
        end else begin
            irq_status_reg <= irq_status_reg | flag_rise;
        end
    end

    // Interrupt mask
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_mask_reg <= RST_BYTE;
        end else if (write_hit(reg_req, OFS_IRQ_MASK)) begin
            irq_mask_reg <= reg_req.wdata;
        end
    end

    // Interrupt outputs
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_reg <= 1'b0;
            pin_irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_status_reg & irq_mask_reg);
            pin_irq_reg <= |pin_event_flags_reg;
        end
    end

    assign irq = irq_reg;
    assign pin_irq_req = pin_irq_reg;

    // read back; flags show hardware state in both modes
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= RST_BYTE;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                OFS_PIN_IRQ_CONTROL: rdata_reg <= pin_irq_control_reg;
                OFS_FALLING_LOW_EN: rdata_reg <= falling_low_enable_reg;
                OFS_RISING_HIGH_EN: rdata_reg <= rising_high_enable_reg;
                OFS_PIN_EVENT_FLAGS: rdata_reg <= pin_event_flags_reg;
                OFS_EXT_PRIO_LOW: rdata_reg <= ext_irq_priority_low_reg;
                OFS_EXT_PRIO_HIGH: rdata_reg <= ext_irq_priority_high_reg;
                OFS_IRQ_STATUS: rdata_reg <= irq_status_reg;
                OFS_IRQ_MASK: rdata_reg <= irq_mask_reg;
                default: rdata_reg <= RST_BYTE;
            endcase
        end else begin
            rdata_reg <= RST_BYTE;
        end
    end

    assign reg_rdata = rdata_reg;

    // Marks that one full cycle out of reset has passed
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            started_reg <= 1'b0;
        end else begin
            started_reg <= 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking

    default disable iff (!resetn);

    // Enabled edge sets its flag on the next edge
    a_edge_sets_flag: assert property (
        (edge_set != 8'h00) |=> ((pin_event_flags_reg & $past(edge_set)) == $past(edge_set))
    ) else $error("enabled edge did not set its flag");

    // Edge flag holds while nothing writes it
    a_edge_flag_holds: assert property (
        started_reg && !wr_flags && !wr_control
        |=> ((pin_event_flags_reg & $past(pin_event_flags_reg) & $past(edge_mask))
             == ($past(pin_event_flags_reg) & $past(edge_mask)))
    ) else $error("edge flag dropped without a write");

    // Level flag tracks inverted input one cycle later
    a_level_tracks_pin: assert property (
        started_reg |=> ((pin_event_flags_reg & ~$past(edge_mask))
                         == (~$past(chan_cur_reg) & ~$past(edge_mask)))
    ) else $error("level flag does not follow inverted input");

    // Software write lands on edge flags when no edge competes
    a_edge_flag_write: assert property (
        wr_flags && !wr_control && (edge_set == 8'h00)
        |=> ((pin_event_flags_reg & $past(edge_mask))
             == ($past(reg_req.wdata) & $past(edge_mask)))
    ) else $error("edge flag write not taken");

    // Set beats a same-cycle clear
    a_set_beats_clear: assert property (
        wr_flags && (edge_set != 8'h00)
        |=> ((pin_event_flags_reg & $past(edge_set)) == $past(edge_set))
    ) else $error("software clear beat a hardware set");

    // Selected port reaches the channels after one cycle
    a_port_select: assert property (
        started_reg |=> (chan_cur_reg == $past(port_sync[port_group_select]))
    ) else $error("channel sample not from selected port");

    // Low bit of the pin and timer two levels follows a low-register write
    a_prio_low_write: assert property (
        write_hit(reg_req, OFS_EXT_PRIO_LOW)
        |=> (ext_prio_level[SRC_PIN_IRQ][0] == $past(reg_req.wdata[SRC_PIN_IRQ]))
            && (ext_prio_level[SRC_TIMER_TWO][0] == $past(reg_req.wdata[SRC_TIMER_TWO]))
    ) else $error("priority low bit not applied");

    // Interrupt follows unmasked status by one cycle
    a_irq_follows: assert property (
        ((irq_status_reg & irq_mask_reg) != 8'h00) |=> irq
    ) else $error("unmasked status did not raise interrupt");

    // Read data stand only in the cycle after a read
    a_rdata_idle: assert property (
        !reg_req.rd |=> (reg_rdata == 8'h00)
    ) else $error("read data outside read answer cycle");

    // Flag register read returns flag state
    a_flag_readback: assert property (
        reg_req.rd && (reg_req.addr == OFS_PIN_EVENT_FLAGS)
        |=> (reg_rdata == $past(pin_event_flags_reg))
    ) else $error("flag register read mismatch");

    // Status bit stays set until written with a one
    a_status_sticky: assert property (
        !wr_status |=> ((irq_status_reg & $past(irq_status_reg)) == $past(irq_status_reg))
    ) else $error("status bit dropped without a clear");

    // New flag event beats a same-cycle status clear
    a_status_set_wins: assert property (
        wr_status && (flag_rise != 8'h00)
        |=> ((irq_status_reg & $past(flag_rise)) == $past(flag_rise))
    ) else $error("status clear beat a new event");

    // Pin request follows any set flag by one cycle
    a_pin_req_follows: assert property (
        started_reg |=> (pin_irq_req == ($past(pin_event_flags_reg) != 8'h00))
    ) else $error("pin request does not follow flags");

    // Level pair six and seven tracks inverted input
    a_pair_type_level: assert property (
        (pin_irq_control_reg[CTL_TYPE_67] == TYPE_LEVEL) && started_reg
        |=> (pin_event_flags_reg[7:6] == ~$past(chan_cur_reg[7:6]))
    ) else $error("level pair flags do not follow input");

    // Edge flag set only by an input change
    a_edge_needs_change: assert property (
        !wr_flags && !wr_control
        |=> ((pin_event_flags_reg & ~$past(pin_event_flags_reg) & $past(edge_mask)
              & ~$past(chan_cur_reg ^ chan_prev_reg)) == 8'h00)
    ) else $error("edge flag set without an input edge");

    // High bit of the watchdog level follows its register write
    a_prio_high_write: assert property (
        write_hit(reg_req, OFS_EXT_PRIO_HIGH)
        |=> (ext_prio_level[SRC_WATCHDOG][1] == $past(reg_req.wdata[SRC_WATCHDOG]))
    ) else $error("priority high bit not applied");

endmodule

`default_nettype wire

// ### hw/pin_irq_pkg.sv
package pin_irq_pkg;

    // Register offsets on the special function register bus
    localparam logic [7:0] OFS_PIN_IRQ_CONTROL = 8'hE9;
    localparam logic [7:0] OFS_FALLING_LOW_EN = 8'hEA;
    localparam logic [7:0] OFS_RISING_HIGH_EN = 8'hEB;
    localparam logic [7:0] OFS_PIN_EVENT_FLAGS = 8'hEC;
    localparam logic [7:0] OFS_EXT_PRIO_LOW = 8'hEF;
    localparam logic [7:0] OFS_EXT_PRIO_HIGH = 8'hF7;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'hF8;
    localparam logic [7:0] OFS_IRQ_MASK = 8'hF9;

    // Values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_PORT_SEL = 2'h0;

    // Control register field positions
    localparam int CTL_TYPE_67 = 7;
    localparam int CTL_TYPE_45 = 6;
    localparam int CTL_TYPE_3 = 5;
    localparam int CTL_TYPE_0 = 2;
    localparam int CTL_PSEL_LSB = 0;
    localparam int CTL_PSEL_MSB = 1;

    // Trigger type encoding
    localparam logic TYPE_LEVEL = 1'b0;
    localparam logic TYPE_EDGE = 1'b1;

    // Extended source positions in the priority registers
    localparam int SRC_TWOWIRE = 0;
    localparam int SRC_PIN_IRQ = 1;
    localparam int SRC_CAPTURE = 2;
    localparam int SRC_PULSE_WIDTH = 3;
    localparam int SRC_WATCHDOG = 4;
    localparam int SRC_FAULT_BRAKE = 5;
    localparam int SRC_SERIAL_PERIPH = 6;
    localparam int SRC_TIMER_TWO = 7;

    // Depth of the pin synchroniser
    localparam int SYNC_STAGES = 2;

    // One bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    // Four ports of eight pins
    typedef logic [3:0][7:0] port_pins_t;

    // Priority level per extended source, {high bit, low bit}
    typedef logic [7:0][1:0] prio_levels_t;

endpackage

// ### hw/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 32
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // Two-stage synchroniser, first stage read only by the second
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

`default_nettype wire
